// File: vdc_defines.svh
// Purpose: constants for the video converter input control block
// Assumes: one clock hclk at 200 MHz, AHB-Lite register access
// Notes: levels are in quarter-IRE steps below full scale (0 = full scale)
//
// Functional notes
// - Pixel code and all controls are captured together on the same strobe.
// - Input registers load only on the strobe's leading edge and hold otherwise.
// - The pixel code is 8 bits, first input the msb and eighth the lsb.
// - The pixel code maps onto 256 evenly spaced levels from black to white.
// - Highlight low adds about ten percent of grey scale to any selected level.
// - Blanking low forces the blanking level placed by the pedestal setting.
// - Sync low selects a level below blanking, a negative-going sync pulse.
// - Force-white low ignores the pixel code and selects the top of grey scale.
// - Sync and blanking beat force-white and code; force-white beats code.
// - Pedestal settings 0, 7.5, 10 and 20 IRE place blanking that far below reference black (0 leaves it at black).
// - Reference white sits 10 IRE below full-scale output.
// - Sync, blanking and force-white are inactive high and act only when low.
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH

`define VDC_OFS_CTRL 12'h000
`define VDC_OFS_PIXEL 12'h004
`define VDC_OFS_STATUS 12'h008
`define VDC_OFS_LEVEL 12'h00C

`define VDC_CTRL_PED_LSB 0
`define VDC_CTRL_PED_MSB 1
`define VDC_CTRL_SRC_BIT 2
`define VDC_CTRL_STROBE_BIT 3
`define VDC_PIX_CODE_MSB 7
`define VDC_PIX_BRIGHT_N_BIT 8
`define VDC_PIX_WHITE_N_BIT 9
`define VDC_PIX_BLANK_N_BIT 10
`define VDC_PIX_SYNC_N_BIT 11
`define VDC_PIX_RESET 32'h00000F00

// Quarter-IRE units: 100 IRE of grey scale is 400 steps
`define VDC_Q_WHITE 16'h0028
`define VDC_Q_GREY 16'h0190
`define VDC_Q_BRIGHT 16'h0028
`define VDC_Q_SYNC 16'h00A0
`define VDC_Q_PED0 16'h0000
`define VDC_Q_PED75 16'h001E
`define VDC_Q_PED10 16'h0028
`define VDC_Q_PED20 16'h0050
`define VDC_CODE_MAX 16'h00FF

`endif

// File: vdc_pkg.sv
// Purpose: types for the video converter input control block
// Assumes: used with vdc_defines.svh
// Notes: none
package vdc_pkg;
    typedef enum logic [1:0] {VDC_PED_0, VDC_PED_7P5, VDC_PED_10, VDC_PED_20} vdc_ped_t;
    typedef enum logic [2:0] {VDC_SEL_CODE, VDC_SEL_WHITE, VDC_SEL_BLANK,
        VDC_SEL_SYNC} vdc_sel_t;
endpackage

// File: vdc_ctrl.sv
// Purpose: digital front end of a composite video reconstruction converter
// Assumes: strobe and pins synchronous to hclk; software may drive them instead
// Notes: output level is a depth below full scale in quarter-IRE steps, times 255
`include "vdc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module vdc_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Video inputs from the timing controller
    input wire logic sample_strobe,
    input wire logic [7:0] pixel_code,
    input wire logic bright_n,
    input wire logic white_n,
    input wire logic blank_n,
    input wire logic sync_n,
    // Registered output selection
    output vdc_pkg::vdc_sel_t level_sel,
    output logic level_bright,
    output logic [23:0] level_depth
);
    import vdc_pkg::*;

    // Bus state
    logic wr_pend_reg, wr_pend_next;
    logic [11:0] wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [3:0] ctrl_reg, ctrl_next;
    logic [11:0] pix_sw_reg, pix_sw_next;
    // Video state
    logic strobe_d_reg, strobe_d_next;
    logic [7:0] code_reg, code_next;
    logic bright_n_reg, bright_n_next;
    logic white_n_reg, white_n_next;
    logic blank_n_reg, blank_n_next;
    logic sync_n_reg, sync_n_next;
    vdc_sel_t sel_reg, sel_next;
    logic bright_reg, bright_next;
    logic [23:0] depth_reg, depth_next;
    logic [7:0] code_reg_d;
    logic cap_pend_reg, cap_pend_next;

    logic addr_ok;
    logic strobe_in, edge_hit;
    logic [7:0] code_in;
    logic b_in, w_in, k_in, s_in;
    logic [15:0] ped_q;
    vdc_ped_t ped_sel;
    logic [23:0] blank_depth;

    // Every register is a flop, so the slave never needs a wait state
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign level_sel = sel_reg;
    assign level_bright = bright_reg;
    assign level_depth = depth_reg;

    always_comb begin
        addr_ok = hsel && hready && htrans[1];
    end

    // Pin or software source, chosen by the control register
    always_comb begin
        if (ctrl_reg[`VDC_CTRL_SRC_BIT]) begin
            strobe_in = ctrl_reg[`VDC_CTRL_STROBE_BIT];
            code_in = pix_sw_reg[`VDC_PIX_CODE_MSB:0];
            b_in = pix_sw_reg[`VDC_PIX_BRIGHT_N_BIT];
            w_in = pix_sw_reg[`VDC_PIX_WHITE_N_BIT];
            k_in = pix_sw_reg[`VDC_PIX_BLANK_N_BIT];
            s_in = pix_sw_reg[`VDC_PIX_SYNC_N_BIT];
        end else begin
            strobe_in = sample_strobe;
            code_in = pixel_code;
            b_in = bright_n;
            w_in = white_n;
            k_in = blank_n;
            s_in = sync_n;
        end
        // Edge from the sampled level: a strobe held high captures only once
        edge_hit = strobe_in && !strobe_d_reg;
    end

    // Bus next state: writes land in the data phase
    // Unmapped addresses read as zero and ignore writes
    always_comb begin
        wr_pend_next = addr_ok && hwrite;
        wr_addr_next = addr_ok ? haddr : wr_addr_reg;
        hrdata_next = hrdata_reg;
        ctrl_next = ctrl_reg;
        pix_sw_next = pix_sw_reg;
        if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                `VDC_OFS_CTRL: ctrl_next = hwdata[3:0];
                `VDC_OFS_PIXEL: pix_sw_next = hwdata[11:0];
                default: ;
            endcase
        end
        if (addr_ok && !hwrite) begin
            unique case (haddr)
                `VDC_OFS_CTRL: hrdata_next = {28'h0, ctrl_reg};
                `VDC_OFS_PIXEL: hrdata_next = {20'h0, pix_sw_reg};
                `VDC_OFS_STATUS: hrdata_next = {20'h0, sync_n_reg, blank_n_reg,
                    white_n_reg, bright_n_reg, code_reg};
                // Selection field is four bits wide in the read word
                `VDC_OFS_LEVEL: hrdata_next = {3'h0, bright_reg, 1'b0, sel_reg, depth_reg};
                default: hrdata_next = 32'h0;
            endcase
        end
    end

    // Input registers: data and controls share one capture edge
    always_comb begin
        strobe_d_next = strobe_in;
        code_next = code_reg;
        bright_n_next = bright_n_reg;
        white_n_next = white_n_reg;
        blank_n_next = blank_n_reg;
        sync_n_next = sync_n_reg;
        // Capture marker for the checks, high the cycle after each edge
        cap_pend_next = edge_hit;
        if (edge_hit) begin
            code_next = code_in;
            bright_n_next = b_in;
            white_n_next = w_in;
            blank_n_next = k_in;
            sync_n_next = s_in;
        end
    end

    always_comb begin
        // Pedestal moves blanking, and sync with it; reference black stays put
        ped_sel = vdc_ped_t'(ctrl_reg[`VDC_CTRL_PED_MSB:`VDC_CTRL_PED_LSB]);
        unique case (ped_sel)
            VDC_PED_0: ped_q = `VDC_Q_PED0;
            VDC_PED_7P5: ped_q = `VDC_Q_PED75;
            VDC_PED_10: ped_q = `VDC_Q_PED10;
            VDC_PED_20: ped_q = `VDC_Q_PED20;
        endcase
        // Depths scaled by 255 so each code step is exactly grey/255 deep
        // Operands widened first: the scaled depths overflow 16 bits
        blank_depth = (24'(`VDC_Q_WHITE) + 24'(`VDC_Q_GREY) + 24'(ped_q))
            * 24'(`VDC_CODE_MAX);
    end

    // Priority decode from the registered inputs only
    always_comb begin
        bright_next = !bright_n_reg;
        if (!sync_n_reg) begin
            sel_next = VDC_SEL_SYNC;
            depth_next = blank_depth + 24'(`VDC_Q_SYNC * `VDC_CODE_MAX);
        end else if (!blank_n_reg) begin
            sel_next = VDC_SEL_BLANK;
            depth_next = blank_depth;
        end else if (!white_n_reg) begin
            sel_next = VDC_SEL_WHITE;
            depth_next = 24'(`VDC_Q_WHITE * `VDC_CODE_MAX);
        end else begin
            sel_next = VDC_SEL_CODE;
            // 255 equal steps from reference black to reference white
            depth_next = 24'(`VDC_Q_WHITE) * 24'(`VDC_CODE_MAX)
                + 24'(`VDC_Q_GREY) * (24'(`VDC_CODE_MAX) - {16'h0000, code_reg});
        end
        // Highlight applied last so it rides on whichever level won
        if (!bright_n_reg) begin
            depth_next = depth_next - 24'(`VDC_Q_BRIGHT * `VDC_CODE_MAX);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Reset shows reference black with every control inactive
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata_reg <= 32'h00000000;
            ctrl_reg <= 4'h0;
            pix_sw_reg <= 12'hF00;
            strobe_d_reg <= 1'b0;
            code_reg <= 8'h00;
            bright_n_reg <= 1'b1;
            white_n_reg <= 1'b1;
            blank_n_reg <= 1'b1;
            sync_n_reg <= 1'b1;
            cap_pend_reg <= 1'b0;
            sel_reg <= VDC_SEL_CODE;
            bright_reg <= 1'b0;
            depth_reg <= 24'(`VDC_Q_WHITE + `VDC_Q_GREY) * 24'(`VDC_CODE_MAX);
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            ctrl_reg <= ctrl_next;
            pix_sw_reg <= pix_sw_next;
            strobe_d_reg <= strobe_d_next;
            code_reg <= code_next;
            bright_n_reg <= bright_n_next;
            white_n_reg <= white_n_next;
            blank_n_reg <= blank_n_next;
            sync_n_reg <= sync_n_next;
            cap_pend_reg <= cap_pend_next;
            sel_reg <= sel_next;
            bright_reg <= bright_next;
            depth_reg <= depth_next;
        end
    end

    // Helper for checking: code one cycle back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_reg_d <= 8'h00;
        end else begin
            code_reg_d <= code_reg;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Capture and priority checks
    capture_on_edge_a: assert property (edge_hit |=> code_reg == $past(code_in))
        else $error("code not captured on strobe edge");
    hold_without_edge_a: assert property (!edge_hit |=> $stable(code_reg)
        && $stable(sync_n_reg) && $stable(blank_n_reg) && $stable(white_n_reg)
        && $stable(bright_n_reg))
        else $error("input registers changed without edge");
    ctrl_aligned_a: assert property (edge_hit |=> sync_n_reg == $past(s_in)
        && blank_n_reg == $past(k_in))
        else $error("controls not aligned with code");
    sync_wins_a: assert property (!sync_n_reg |=> level_sel == VDC_SEL_SYNC)
        else $error("sync not selected");
    blank_prio_a: assert property (sync_n_reg && !blank_n_reg |=> level_sel == VDC_SEL_BLANK)
        else $error("blank not selected");
    white_prio_a: assert property (sync_n_reg && blank_n_reg && !white_n_reg
        |=> level_sel == VDC_SEL_WHITE)
        else $error("force white not selected");
    bright_follow_a: assert property (edge_hit ##1 1'b1 |=> level_bright == !$past(bright_n_reg))
        else $error("highlight not applied");
    sync_below_a: assert property (level_sel == VDC_SEL_SYNC |-> level_depth > blank_depth
        - (level_bright ? 24'(`VDC_Q_BRIGHT * `VDC_CODE_MAX) : 24'h0))
        else $error("sync not below blanking");
    step_mono_a: assert property (cap_pend_reg && sync_n_reg && blank_n_reg && white_n_reg
        && bright_n_reg && code_reg > code_reg_d ##1 sel_reg == VDC_SEL_CODE
        |-> depth_reg < 24'(`VDC_Q_WHITE + `VDC_Q_GREY) * 24'(`VDC_CODE_MAX))
        else $error("code step out of range");

    // Level checks against the fixed quarter-IRE ladder
    idle_code_a: assert property (sync_n_reg && blank_n_reg && white_n_reg
        |=> level_sel == VDC_SEL_CODE)
        else $error("inactive controls did not select the code");
    code_top_a: assert property (sync_n_reg && blank_n_reg && white_n_reg && bright_n_reg
        && code_reg == 8'(`VDC_CODE_MAX)
        |=> level_depth == 24'(`VDC_Q_WHITE) * 24'(`VDC_CODE_MAX))
        else $error("top code not at reference white");
    code_bottom_a: assert property (sync_n_reg && blank_n_reg && white_n_reg && bright_n_reg
        && code_reg == 8'h00
        |=> level_depth == 24'(`VDC_Q_WHITE + `VDC_Q_GREY) * 24'(`VDC_CODE_MAX))
        else $error("zero code not at reference black");
    white_depth_a: assert property (sync_n_reg && blank_n_reg && !white_n_reg && bright_n_reg
        |=> level_depth == 24'(`VDC_Q_WHITE) * 24'(`VDC_CODE_MAX))
        else $error("force white depth wrong");
    white_top_a: assert property (sync_n_reg && blank_n_reg && !white_n_reg && !bright_n_reg
        |=> level_depth == 24'h000000)
        else $error("highlighted white not at full scale");
    blank_black_a: assert property (ped_sel == VDC_PED_0 && sync_n_reg && !blank_n_reg
        && bright_n_reg
        |=> level_depth == 24'(`VDC_Q_WHITE + `VDC_Q_GREY) * 24'(`VDC_CODE_MAX))
        else $error("zero pedestal blanking not at reference black");
    blank_deep_a: assert property (ped_sel == VDC_PED_20 && sync_n_reg && !blank_n_reg
        && bright_n_reg |=> level_depth
        == 24'(`VDC_Q_WHITE + `VDC_Q_GREY + `VDC_Q_PED20) * 24'(`VDC_CODE_MAX))
        else $error("deepest pedestal blanking wrong");
    sync_depth_a: assert property (ped_sel == VDC_PED_0 && !sync_n_reg && bright_n_reg
        |=> level_depth
        == 24'(`VDC_Q_WHITE + `VDC_Q_GREY + `VDC_Q_SYNC) * 24'(`VDC_CODE_MAX))
        else $error("sync depth wrong");
    sync_bright_a: assert property (ped_sel == VDC_PED_0 && !sync_n_reg && !bright_n_reg
        |=> level_depth == 24'(`VDC_Q_WHITE + `VDC_Q_GREY + `VDC_Q_SYNC - `VDC_Q_BRIGHT)
        * 24'(`VDC_CODE_MAX))
        else $error("highlight not applied under sync");
    level_hold_a: assert property ($stable(code_reg) && $stable(sync_n_reg)
        && $stable(blank_n_reg) && $stable(white_n_reg) && $stable(bright_n_reg)
        && $stable(ctrl_reg) |=> $stable(level_depth) && $stable(level_sel))
        else $error("level changed without new input");

    // Main scenarios the bench should reach
    cv_sync_c: cover property (!blank_n_reg ##1 !sync_n_reg ##[1:8] sync_n_reg);
    cv_white_c: cover property (level_sel == VDC_SEL_WHITE && level_bright);
    cv_code_c: cover property (edge_hit ##2 level_sel == VDC_SEL_CODE);
    cv_soft_c: cover property (edge_hit && ctrl_reg[`VDC_CTRL_SRC_BIT]);
    cv_ped20_c: cover property (ped_sel == VDC_PED_20 && level_sel == VDC_SEL_BLANK);
endmodule
`default_nettype wire

// File: vdc_tmodel.sv
// Purpose: timing controller model driving pixel code, controls and strobe
// Assumes: one go pulse per sample, at least five cycles apart
// Notes: once hold time runs out while the strobe is still high, data turns inverse
`timescale 1ns/10ps
`default_nettype none
module vdc_tmodel (
    // Clock and request
    input wire logic hclk,
    input wire logic go,
    input wire logic [7:0] code_in,
    input wire logic [3:0] ctl_in,
    // Video pins
    output logic sample_strobe,
    output logic [7:0] pixel_code,
    output logic bright_n,
    output logic white_n,
    output logic blank_n,
    output logic sync_n
);
    logic [1:0] ph = 2'h0;
    initial begin
        sample_strobe = 1'b0;
        pixel_code = 8'h00;
        {sync_n, blank_n, white_n, bright_n} = 4'hF;
    end
    always @(posedge hclk) begin
        ph <= {ph[0], go};
        if (go) begin
            sample_strobe <= 1'b1;
            pixel_code <= code_in;
            {sync_n, white_n, bright_n} <= {ctl_in[3], ctl_in[1:0]};
            // Sync never shows without blanking around it
            blank_n <= ctl_in[2] & ctl_in[3];
        end else if (ph[0]) begin
            pixel_code <= ~pixel_code;
            {white_n, bright_n} <= ~{white_n, bright_n};
        end else if (ph[1]) begin
            sample_strobe <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the video converter input control
// Assumes: pins source selected, zero wait state slave
// Notes: random samples from a fixed LFSR seed plus corner samples
`include "vdc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    import vdc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, go, hreadyout, hresp;
    logic sample_strobe, bright_n, white_n, blank_n, sync_n;
    logic [11:0] haddr;
    logic [1:0] htrans, ped;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0] code_in, pixel_code;
    logic [3:0] ctl_in;
    logic [15:0] seed;
    vdc_sel_t level_sel;
    logic level_bright;
    logic [23:0] level_depth;
    int n_mismatch, compares, cyc;
    int pq[4] = '{0, 30, 40, 80};

    vdc_ctrl u_vdc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_strobe(sample_strobe),
        .pixel_code(pixel_code), .bright_n(bright_n), .white_n(white_n), .blank_n(blank_n),
        .sync_n(sync_n), .level_sel(level_sel), .level_bright(level_bright),
        .level_depth(level_depth));
    vdc_tmodel u_vdc_tmodel (.hclk(hclk), .go(go), .code_in(code_in), .ctl_in(ctl_in),
        .sample_strobe(sample_strobe), .pixel_code(pixel_code), .bright_n(bright_n),
        .white_n(white_n), .blank_n(blank_n), .sync_n(sync_n));

    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic vdc_sel_t exp_sel(input logic [3:0] c);
        if (!c[3]) return VDC_SEL_SYNC;
        if (!c[2]) return VDC_SEL_BLANK;
        if (!c[1]) return VDC_SEL_WHITE;
        return VDC_SEL_CODE;
    endfunction
    function automatic logic [23:0] exp_depth(input logic [7:0] k, input logic [3:0] c);
        int d;
        case (exp_sel(c))
            VDC_SEL_SYNC: d = (600 + pq[ped]) * 255;
            VDC_SEL_BLANK: d = (440 + pq[ped]) * 255;
            VDC_SEL_WHITE: d = 10200;
            default: d = 10200 + 400 * (255 - int'(k));
        endcase
        if (!c[0]) d = d - 10200;
        return 24'(d);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic frame(input logic [7:0] k, input logic [3:0] c);
        logic [3:0] ce;
        ce = {c[3], c[2] & c[3], c[1:0]};
        code_in <= k;
        ctl_in <= c;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        repeat (5) @(posedge hclk);
        check(32'(level_sel), 32'(exp_sel(ce)));
        check(32'(level_bright), {31'h0, ~c[0]});
        check(32'(level_depth), 32'(exp_depth(k, ce)));
        ahb(1'b0, `VDC_OFS_STATUS, 32'h0);
        check(rd, {20'h0, ce, k});
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, go, htrans, hsize, haddr, hwdata} = '0;
        code_in = 8'h00;
        ctl_in = 4'hF;
        seed = 16'h0047;
        ped = 2'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        check(32'(level_depth), 32'd112200);
        check(32'(level_sel), 32'(VDC_SEL_CODE));
        check(32'(hresp), 32'h0);
        ahb(1'b0, `VDC_OFS_STATUS, 32'h0);
        check(rd, 32'h00000F00);
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            ped = 2'(p);
            ahb(1'b1, `VDC_OFS_CTRL, {30'h0, ped});
            ahb(1'b0, `VDC_OFS_CTRL, 32'h0);
            check(rd, {30'h0, ped});
            frame(8'hFF, 4'hB);
            frame(8'h00, 4'h2);
            frame(8'h5A, 4'h7);
        end
        $display("test pedestal done");
        frame(8'h00, 4'hF);
        frame(8'hFF, 4'hF);
        frame(8'h80, 4'hE);
        frame(8'h33, 4'hD);
        frame(8'h01, 4'hC);
        $display("test corners done");
        // Software source: the pixel register stands in for the pins
        ped = 2'h0;
        ahb(1'b1, `VDC_OFS_PIXEL, 32'h00000E5A);
        ahb(1'b0, `VDC_OFS_PIXEL, 32'h0);
        check(rd, 32'h00000E5A);
        ahb(1'b1, `VDC_OFS_CTRL, 32'h0000000C);
        repeat (3) @(posedge hclk);
        check(32'(level_sel), 32'(exp_sel(4'hE)));
        check(32'(level_bright), 32'h1);
        check(32'(level_depth), 32'(exp_depth(8'h5A, 4'hE)));
        ahb(1'b0, `VDC_OFS_STATUS, 32'h0);
        check(rd, 32'h00000E5A);
        ahb(1'b0, `VDC_OFS_LEVEL, 32'h0);
        check(rd, {3'h0, 1'b1, 4'(exp_sel(4'hE)), exp_depth(8'h5A, 4'hE)});
        ahb(1'b1, `VDC_OFS_CTRL, 32'h0);
        $display("test software source done");
        repeat (40) begin
            seed = lfsr(seed);
            ped = seed[13:12];
            ahb(1'b1, `VDC_OFS_CTRL, {30'h0, ped});
            frame(seed[7:0], seed[11:8]);
        end
        $display("test random done");
        ahb(1'b1, 12'h010, 32'hFFFFFFFF);
        ahb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0);
        $display("test unmapped done");
        report_and_stop;
    end
endmodule
`default_nettype wire
